// ==== verilog/two_wire_bus_controller_regs.v ====
// Implementation choices: the APB register port and the register addresses.
`include "twb_consts.vh"
`default_nettype none
module two_wire_bus_controller_regs
(
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        i_scl,
  output wire        o_scl,
  output wire        o_scl_oe,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe,
  output wire        o_irq
);

  localparam [6:0] S_IDLE  = 7'b0000001;
  localparam [6:0] S_START = 7'b0000010;
  localparam [6:0] S_LOW   = 7'b0000100;
  localparam [6:0] S_HIGH  = 7'b0001000;
  localparam [6:0] S_WAIT  = 7'b0010000;
  localparam [6:0] S_STOP  = 7'b0100000;
  localparam [6:0] S_RSTRT = 7'b1000000;

  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0] ctrl_q;
  reg  [7:0] freq_q;
  reg  [6:0] own_addr_q;
  reg  [7:0] tx_q;
  reg  [7:0] rx_q;
  reg        done_q, aas_q, busy_q, arb_lost_flag_q, srw_q, pend_q, nack_q;
  reg  [6:0] st_q;
  reg  [1:0] ph_q;
  reg  [3:0] bit_q;
  reg  [7:0] sh_q;
  reg        mst_q;
  reg        sda_lo_q, scl_lo_q;
  reg        addr_cyc_q;
  reg        slv_act_q, slv_addr_q;
  reg        scl_prev_q, sda_prev_q;
  reg  [3:0] sbit_q;
  reg  [7:0] ssh_q;
  wire [1:0] line;
  wire       tick;
  wire       scl_s = line[1];
  wire       sda_s = line[0];
  wire       en = ctrl_q[`B_MODULE_ON];
  wire       tx = ctrl_q[`B_TX_DIR];

  pin_sync u_sync
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .i_pin  ({i_scl, i_sda}),
    .o_pin  (line)
  );

  rate_divider u_rate
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .i_run  (st_q != S_IDLE),
    .i_freq (freq_q),
    .o_tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait APB slave
  wire wr = psel & penable & pwrite & i_ce;
  wire rd = psel & penable & ~pwrite & i_ce;
  wire wr_ctrl = wr & (paddr == `A_BUS_CONTROL);
  wire wr_stat = wr & (paddr == `A_BUS_STATUS);
  wire wr_data = wr & (paddr == `A_BUS_DATA);
  wire rd_data = rd & (paddr == `A_BUS_DATA);
  wire mapped  = (paddr == `A_BUS_ADDR) | (paddr == `A_BUS_FREQ) |
                 (paddr == `A_BUS_CONTROL) | (paddr == `A_BUS_STATUS) |
                 (paddr == `A_BUS_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @*
  begin
    prdata = 32'h00000000;
    case (paddr)
      `A_BUS_ADDR:    prdata[7:1] = own_addr_q;
      `A_BUS_FREQ:    prdata[7:0] = freq_q;
      `A_BUS_CONTROL: prdata[7:0] = {ctrl_q[7:3], 3'b000};
      `A_BUS_STATUS:  prdata[7:0] = {done_q, aas_q, busy_q, arb_lost_flag_q,
                                     1'b0, srw_q, pend_q, nack_q};
      `A_BUS_DATA:    prdata[7:0] = rx_q;
      default:        prdata = 32'h00000000;
    endcase
  end

  assign o_irq = pend_q & ctrl_q[`B_IRQ_ALLOW];

  // Slave data path active only once addressed
  wire own_xfer = mst_q | slv_act_q;
  wire go_tx = wr_data & tx & own_xfer;
  wire go_rx = rd_data & ~tx & own_xfer;

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection
  wire start_det = scl_prev_q & scl_s & sda_prev_q & ~sda_s;
  wire stop_det  = scl_prev_q & scl_s & ~sda_prev_q & sda_s;
  wire scl_rise  = ~scl_prev_q & scl_s;
  wire scl_fall  = scl_prev_q & ~scl_s;

  // Master lost the bus: drove 1, sampled 0
  wire lost = mst_q & (st_q == S_HIGH) & ~sda_lo_q & ~sda_s &
              (bit_q < 4'd8 ? tx | addr_cyc_q : 1'b0);
  wire bad_repeat_start_cmd = wr_ctrl & pwdata[`B_REP_START] &
                  (~mst_q | ~ctrl_q[`B_MASTER_SEL]);
  wire m_done = mst_q & (st_q == S_HIGH) & tick & scl_s & (ph_q == 2'd3) &
                (bit_q == 4'd8);
  wire s_match;
  wire s_done = slv_act_q & scl_fall & (sbit_q == 4'd9);
  wire ev_done = m_done | s_done;
  wire ev_arb  = lost | bad_repeat_start_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and flags
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_q     <= `RST_CONTROL;
      freq_q     <= `RST_FREQ;
      own_addr_q <= 7'h00;
      tx_q       <= `RST_DATA;
      done_q     <= 1'b1;
      aas_q      <= 1'b0;
      busy_q     <= 1'b0;
      arb_lost_flag_q     <= 1'b0;
      srw_q      <= 1'b0;
      pend_q     <= 1'b0;
      nack_q     <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      if (wr_ctrl)
        ctrl_q <= {pwdata[7:3], 3'b000};
      else if (ev_arb)
        ctrl_q[`B_MASTER_SEL] <= 1'b0;
      if (wr & (paddr == `A_BUS_FREQ))
        freq_q <= pwdata[7:0];
      if (wr & (paddr == `A_BUS_ADDR))
        own_addr_q <= pwdata[7:1];
      if (go_tx)
        tx_q <= pwdata[7:0];
      if (ev_done)
        done_q <= 1'b1;
      else if (go_tx | go_rx | (mst_q & st_q == S_START))
        done_q <= 1'b0;
      if (s_match)
        aas_q <= 1'b1;
      else if (wr_ctrl)
        aas_q <= 1'b0;
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;
      if (ev_arb)
        arb_lost_flag_q <= 1'b1;
      else if (wr_stat & pwdata[`B_ARB_LOST])
        arb_lost_flag_q <= 1'b0;
      if (ev_done | ev_arb | s_match)
        pend_q <= 1'b1;
      else if (wr_stat & pwdata[`B_IRQ_PEND])
        pend_q <= 1'b0;
      if (s_match)
        srw_q <= ssh_q[0];
      if (mst_q & (st_q == S_HIGH) & tick & scl_s & (ph_q == 2'd1) &
          (bit_q == 4'd8) & (tx | addr_cyc_q))
        nack_q <= sda_s;
      if (!en)
        busy_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master engine: six ticks per bit (two low, four high)
  wire ms_set = wr_ctrl & pwdata[`B_MASTER_SEL] & ~ctrl_q[`B_MASTER_SEL];
  wire ms_clr = wr_ctrl & ~pwdata[`B_MASTER_SEL] & ctrl_q[`B_MASTER_SEL];
  wire repeat_start_cmd   = wr_ctrl & pwdata[`B_REP_START] & mst_q &
                ctrl_q[`B_MASTER_SEL];
  // Data access during START is held until the bus waits for software
  reg        go_pend_q;
  wire       launch_tx = go_tx | (go_pend_q & tx);
  wire [7:0] launch_d  = go_tx ? pwdata[7:0] : tx_q;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q       <= S_IDLE;
      ph_q       <= 2'd0;
      bit_q      <= 4'd0;
      sh_q       <= 8'h00;
      mst_q      <= 1'b0;
      sda_lo_q   <= 1'b0;
      scl_lo_q   <= 1'b0;
      addr_cyc_q <= 1'b0;
      rx_q       <= `RST_DATA;
      go_pend_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (!en | lost)
      begin
        st_q      <= S_IDLE;
        mst_q     <= 1'b0;
        sda_lo_q  <= 1'b0;
        scl_lo_q  <= 1'b0;
        go_pend_q <= 1'b0;
      end
      else
      begin
        if ((go_tx | go_rx) & mst_q & (st_q != S_WAIT))
          go_pend_q <= 1'b1;
        else if (st_q == S_WAIT)
          go_pend_q <= 1'b0;
        case (st_q)
          S_IDLE:
            if (ms_set & ~busy_q)
            begin
              st_q     <= S_START;
              mst_q    <= 1'b1;
              ph_q     <= 2'd0;
            end
          S_START:
            if (tick)
            begin
              ph_q <= ph_q + 2'd1;
              if (ph_q == 2'd1)
                sda_lo_q <= 1'b1;
              if (ph_q == 2'd3)
              begin
                scl_lo_q   <= 1'b1;
                addr_cyc_q <= 1'b1;
                st_q       <= S_WAIT;
              end
            end
          S_WAIT:
          begin
            // Release a cycle after the clock falls, never with it
            sda_lo_q <= 1'b0;
            if (ms_clr | (wr_ctrl & ~pwdata[`B_MASTER_SEL]))
            begin
              st_q     <= S_STOP;
              sda_lo_q <= 1'b1;
              ph_q     <= 2'd0;
            end
            else if (repeat_start_cmd)
            begin
              st_q     <= S_RSTRT;
              sda_lo_q <= 1'b0;
              ph_q     <= 2'd0;
            end
            else if (go_tx | go_rx | go_pend_q)
            begin
              sh_q     <= launch_tx ? launch_d : 8'hff;
              bit_q    <= 4'd0;
              ph_q     <= 2'd0;
              sda_lo_q <= launch_tx & ~launch_d[7];
              st_q     <= S_LOW;
            end
          end
          S_LOW:
            if (tick)
            begin
              ph_q <= ph_q + 2'd1;
              // Data moves only while the clock is well low
              if (ph_q == 2'd0)
              begin
                if (bit_q == 4'd8)
                  sda_lo_q <= ~(tx | addr_cyc_q) &
                              ~ctrl_q[`B_ACK_SUPP];
                else
                  sda_lo_q <= (tx | addr_cyc_q) & ~sh_q[7];
              end
              if (ph_q == 2'd1)
              begin
                scl_lo_q <= 1'b0;
                ph_q     <= 2'd0;
                st_q     <= S_HIGH;
              end
            end
          S_HIGH:
            if (tick & scl_s)
            begin
              ph_q <= ph_q + 2'd1;
              if ((ph_q == 2'd1) & (bit_q < 4'd8))
              begin
                sh_q <= {sh_q[6:0], sda_s};
                if (bit_q == 4'd7 & ~(tx | addr_cyc_q))
                  rx_q <= {sh_q[6:0], sda_s};
              end
              if (ph_q == 2'd3)
              begin
                scl_lo_q <= 1'b1;
                ph_q     <= 2'd0;
                if (bit_q == 4'd8)
                begin
                  st_q       <= S_WAIT;
                  addr_cyc_q <= 1'b0;
                end
                else
                begin
                  bit_q <= bit_q + 4'd1;
                  st_q  <= S_LOW;
                end
              end
            end
          S_RSTRT:
            if (tick)
            begin
              ph_q <= ph_q + 2'd1;
              if (ph_q == 2'd1)
                scl_lo_q <= 1'b0;
              if (ph_q == 2'd3)
              begin
                st_q <= S_START;
                ph_q <= 2'd0;
              end
            end
          S_STOP:
            if (tick)
            begin
              ph_q <= ph_q + 2'd1;
              if (ph_q == 2'd1)
                scl_lo_q <= 1'b0;
              if (ph_q == 2'd3)
              begin
                sda_lo_q <= 1'b0;
                mst_q    <= 1'b0;
                st_q     <= S_IDLE;
              end
            end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave receiver of calling address and data
  reg slv_ack_q, slv_drv_q;
  // Slave-received bytes held apart; master path owns rx_q
  reg [7:0] rx_q_s;
  assign s_match = slv_addr_q & scl_rise & (sbit_q == 4'd7) &
                   (ssh_q[6:0] == own_addr_q) & ~mst_q;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sbit_q     <= 4'd0;
      ssh_q      <= 8'h00;
      slv_act_q  <= 1'b0;
      slv_addr_q <= 1'b0;
      slv_ack_q  <= 1'b0;
      slv_drv_q  <= 1'b0;
      rx_q_s     <= `RST_DATA;
    end
    else if (i_ce)
    begin
      if (!en | stop_det)
      begin
        slv_act_q  <= 1'b0;
        slv_addr_q <= 1'b0;
        slv_ack_q  <= 1'b0;
        sbit_q     <= 4'd0;
      end
      else if (start_det)
      begin
        slv_act_q  <= 1'b0;
        slv_addr_q <= 1'b1;
        sbit_q     <= 4'd0;
      end
      else
      begin
        if (scl_rise & sbit_q < 4'd8)
          ssh_q <= {ssh_q[6:0], sda_s};
        if (s_match)
        begin
          slv_act_q  <= 1'b1;
          slv_ack_q  <= 1'b1;
        end
        if (scl_fall)
        begin
          sbit_q <= (sbit_q == 4'd9) ? 4'd1 : sbit_q + 4'd1;
          if (sbit_q == 4'd8)
          begin
            slv_drv_q <= slv_ack_q |
                         (slv_act_q & ~tx & ~ctrl_q[`B_ACK_SUPP]);
            slv_addr_q <= 1'b0;
            if (slv_act_q & ~tx & ~slv_ack_q)
              rx_q_s <= ssh_q;
          end
          else
          begin
            slv_drv_q <= 1'b0;
            slv_ack_q <= 1'b0;
          end
        end
      end
    end
  end

  wire unused_ok = &{1'b0, rx_q_s};

  assign o_sda    = 1'b0;
  assign o_sda_oe = en & (sda_lo_q | slv_drv_q);
  assign o_scl    = 1'b0;
  // Master holds the clock low in S_WAIT until software acts; the slave never stretches
  assign o_scl_oe = en & (scl_lo_q | (st_q == S_WAIT & mst_q));

endmodule
`default_nettype wire

// ==== shared/twb_consts.vh ====
`ifndef TWB_CONSTS_VH
`define TWB_CONSTS_VH
// Register byte addresses
`define A_BUS_ADDR     8'h00
`define A_BUS_FREQ     8'h04
`define A_BUS_CONTROL  8'h08
`define A_BUS_STATUS   8'h0c
`define A_BUS_DATA     8'h10
// Control bit positions
`define B_MODULE_ON    7
`define B_IRQ_ALLOW    6
`define B_MASTER_SEL   5
`define B_TX_DIR       4
`define B_ACK_SUPP     3
`define B_REP_START    2
// Status bit positions
`define B_BYTE_DONE    7
`define B_ADDR_SLAVE   6
`define B_BUSY         5
`define B_ARB_LOST     4
`define B_SLAVE_RW     2
`define B_IRQ_PEND     1
`define B_NACK         0
// Reset values
`define RST_CONTROL    8'h00
`define RST_FREQ       8'h00
`define RST_ADDR       8'h00
`define RST_DATA       8'h00
`endif

// ==== verilog/rate_divider.v ====
`default_nettype none
// Tick generator: one tick per quarter of mul * divider bus clocks; a master bit takes six ticks
module rate_divider
(
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  input  wire       i_run,
  input  wire [7:0] i_freq,
  output reg        o_tick
);

  reg  [11:0] div;
  reg  [13:0] cnt_q;
  wire [13:0] period;

  // Base divider 20..1924 grows with index; simplified monotonic table
  always @*
  begin
    div = 12'd20 + {2'b00, i_freq[5:0], 4'h0} +
          {2'b00, i_freq[5:3], 7'h00};
  end

  // Quarter period, at least one cycle
  assign period = ({2'b00, div} << i_freq[7:6]) >> 2;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q  <= 14'h0000;
      o_tick <= 1'b0;
    end
    else if (i_ce)
    begin
      o_tick <= 1'b0;
      if (!i_run)
        cnt_q <= 14'h0000;
      else if (cnt_q + 14'h0001 >= period)
      begin
        cnt_q  <= 14'h0000;
        o_tick <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 14'h0001;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/pin_sync.v ====
`default_nettype none
// Two-stage synchroniser for the bus lines
module pin_sync
(
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  input  wire [1:0] i_pin,
  output reg  [1:0] o_pin
);

  reg [1:0] meta_q;

  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= 2'b11;
      o_pin  <= 2'b11;
    end
    else if (i_ce)
    begin
      meta_q <= i_pin;
      o_pin  <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ==== test/tw_check_sva.sv ====
`default_nettype none
module tw_check
(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_scl_oe,
  input wire logic        o_sda_oe,
  input wire logic        o_irq
);
  logic [7:0] ctl_q;
  logic       busy_q;
  logic       on;
  logic       acc;
  logic       rd_st;
  assign acc = psel && penable;
  assign on = ctl_q[7];
  assign rd_st = acc && !pwrite && paddr == 8'h0c;
  // Shadow of software's control writes
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      ctl_q <= 8'h00;
    else if (acc && pwrite && paddr == 8'h08)
      ctl_q <= pwdata[7:0];
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      busy_q <= 1'b0;
    else if (i_scl && $fell(i_sda))
      busy_q <= 1'b1;
    else if (i_scl && $rose(i_sda))
      busy_q <= 1'b0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("pslverr wrong");
  a_unmapped_zero: assert property (acc && !pwrite && pslverr |->
    prdata == 32'h0) else $error("unmapped read not zero");
  a_irq_masked: assert property (!ctl_q[6] |-> !o_irq)
    else $error("irq while masked");
  a_irq_flag: assert property (rd_st && ctl_q[6] |-> prdata[1] == o_irq)
    else $error("irq differs from pending");
  a_off_quiet: assert property (!on && !$past(on, 2) |->
    !o_scl_oe && !o_sda_oe) else $error("pins driven while off");
  a_ctl_bits: assert property (acc && !pwrite && paddr == 8'h08 |->
    prdata[2:0] == 3'h0 && prdata[7:6] == ctl_q[7:6]
    && prdata[4:3] == ctl_q[4:3]) else $error("control readback");
  a_stat_fixed: assert property (rd_st |->
    prdata[3] == 1'b0 && prdata[31:8] == 24'h0) else $error("status zeros");
  a_busy_set: assert property (rd_st && on && $past(on, 8) && busy_q
    && $past(busy_q, 8) |-> prdata[5]) else $error("busy not set");
  a_busy_clr: assert property (rd_st && on && $past(on, 8) && !busy_q
    && !$past(busy_q, 8) |-> !prdata[5]) else $error("busy not clear");
  cover property (o_irq);
  cover property (on && busy_q);
  cover property (acc && pslverr);
endmodule
bind two_wire_bus_controller_regs tw_check chk
(
  .i_clk(i_clk), .i_nrst(i_nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .i_scl(i_scl), .i_sda(i_sda),
  .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_irq(o_irq)
);
`default_nettype wire

// ==== test/bus_slave_model.sv ====
`default_nettype none
module bus_slave_model
#(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] TXB  = 8'hc3
)
(
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output var  logic       o_sda_oe,
  output var  logic [7:0] o_last_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_q = 8'h00;
  logic [3:0] cnt_q = 4'd0;
  logic       act_q = 1'b0;
  logic       first_q = 1'b0;
  logic       rd_q = 1'b0;
  logic       go_q = 1'b0;
  initial
  begin
    o_sda_oe = 1'b0;
    o_last_rx = 8'h00;
  end
  // Frame edges count only while the clock line is high
  always @(negedge i_sda)
    if (i_scl)
    begin
      {act_q, first_q, rd_q, go_q} = 4'b1100;
      cnt_q = 4'd0;
    end
  always @(posedge i_sda)
    if (i_scl)
    begin
      act_q = 1'b0;
      o_sda_oe = 1'b0;
    end
  always @(posedge i_scl)
    if (act_q)
    begin
      if (!rd_q && cnt_q < 4'd8)
        sh_q = {sh_q[6:0], i_sda};
      if (rd_q && cnt_q == 4'd8)
        go_q = !i_sda;
      cnt_q = cnt_q + 4'd1;
    end
  // Released line floats to the pull-up level
  always @(negedge i_scl)
    if (act_q)
    begin
      if (cnt_q == 4'd8 && rd_q)
        o_sda_oe = 1'b0;
      else if (cnt_q == 4'd8)
      begin
        if (first_q)
          go_q = sh_q[7:1] == ADDR && sh_q[0];
        else
          o_last_rx = sh_q;
        act_q = !first_q || sh_q[7:1] == ADDR;
        o_sda_oe = act_q;
      end
      else if (cnt_q == 4'd9)
      begin
        cnt_q = 4'd0;
        first_q = 1'b0;
        rd_q = go_q;
        o_sda_oe = rd_q && !TXB[7];
      end
      else if (rd_q && cnt_q != 4'd0)
        o_sda_oe = !TXB[3'd7 - cnt_q[2:0]];
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`include "twb_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic       er;
  } row_t;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        o_scl_oe;
  logic        o_sda_oe;
  logic        o_irq;
  logic        sv_oe;
  logic [7:0]  rx_b;
  logic [7:0]  rd_q;
  logic        err_q;
  wire         scl = !o_scl_oe;
  wire         sda = !(o_sda_oe || sv_oe);
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  row_t        rows [8] = '{
    '{1'b0, `A_BUS_CONTROL, 8'h00, `RST_CONTROL, 1'b0},
    '{1'b0, `A_BUS_STATUS, 8'h00, 8'h80, 1'b0},
    '{1'b0, `A_BUS_DATA, 8'h00, `RST_DATA, 1'b0},
    '{1'b0, 8'h14, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'h14, 8'hff, 8'h00, 1'b1},
    '{1'b1, `A_BUS_CONTROL, 8'h58, 8'h00, 1'b0},
    '{1'b0, `A_BUS_CONTROL, 8'h00, 8'h58, 1'b0},
    '{1'b1, `A_BUS_ADDR, 8'h20, 8'h00, 1'b0}};
  always #10 i_clk = !i_clk;
  two_wire_bus_controller_regs dut
  (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .i_scl(scl),
    .o_scl(), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(),
    .o_sda_oe(o_sda_oe), .o_irq(o_irq)
  );
  bus_slave_model sv
  (
    .i_scl(scl), .i_sda(sda), .o_sda_oe(sv_oe), .o_last_rx(rx_b)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  // Bounded poll of one status bit
  task automatic wait_stat(input int b, input logic v);
    rd_q = ~{8{v}};
    for (int n = 0; n < 3000 && rd_q[b] !== v; n++)
      apb(1'b0, `A_BUS_STATUS, 8'h00);
  endtask
  always @(posedge i_clk)
    if (++cyc == 80000)
    begin
      mismatches++;
      test_done();
    end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("pslverr", {7'h0, rows[i].er}, {7'h0, err_q});
      if (!rows[i].wr)
        chk("prdata", rows[i].e, rd_q);
    end
    $display("test table done");
    apb(1'b1, `A_BUS_CONTROL, 8'h84);
    apb(1'b0, `A_BUS_STATUS, 8'h00);
    chk("arb lost", 8'h12, rd_q & 8'h12);
    apb(1'b0, `A_BUS_CONTROL, 8'h00);
    chk("control", 8'h80, rd_q);
    chk("irq masked", 8'h00, {7'h0, o_irq});
    apb(1'b1, `A_BUS_CONTROL, 8'hc0);
    chk("irq", 8'h01, {7'h0, o_irq});
    apb(1'b1, `A_BUS_STATUS, 8'h12);
    apb(1'b0, `A_BUS_STATUS, 8'h00);
    chk("w1c", 8'h00, rd_q & 8'h12);
    $display("test flags done");
    apb(1'b1, `A_BUS_CONTROL, 8'hb0);
    wait_stat(5, 1'b1);
    apb(1'b1, `A_BUS_DATA, 8'h54);
    apb(1'b0, `A_BUS_STATUS, 8'h00);
    chk("in progress", 8'h00, rd_q & 8'h80);
    wait_stat(7, 1'b1);
    chk("ack", 8'ha2, rd_q & 8'ha3);
    apb(1'b1, `A_BUS_STATUS, 8'h02);
    apb(1'b1, `A_BUS_DATA, 8'ha5);
    wait_stat(7, 1'b1);
    chk("sent", 8'ha5, rx_b);
    apb(1'b1, `A_BUS_CONTROL, 8'hb4);
    apb(1'b1, `A_BUS_DATA, 8'h66);
    wait_stat(7, 1'b1);
    chk("nack", 8'h01, rd_q & 8'h01);
    apb(1'b1, `A_BUS_CONTROL, 8'h80);
    wait_stat(5, 1'b0);
    chk("stop", 8'h00, rd_q & 8'h20);
    $display("test write done");
    apb(1'b1, `A_BUS_CONTROL, 8'hb0);
    apb(1'b1, `A_BUS_DATA, 8'h55);
    wait_stat(7, 1'b1);
    apb(1'b1, `A_BUS_CONTROL, 8'ha0);
    apb(1'b0, `A_BUS_DATA, 8'h00);
    wait_stat(7, 1'b1);
    apb(1'b1, `A_BUS_CONTROL, 8'hb0);
    apb(1'b0, `A_BUS_DATA, 8'h00);
    chk("received", 8'hc3, rd_q);
    apb(1'b0, `A_BUS_STATUS, 8'h00);
    chk("no receive", 8'h80, rd_q & 8'h80);
    apb(1'b1, `A_BUS_CONTROL, 8'h80);
    wait_stat(5, 1'b0);
    $display("test read done");
    test_done();
  end
endmodule
`default_nettype wire
